// *** hdl/crl_pkg.sv ***
`default_nettype none
package crl_pkg;
	// serial command word layout
	localparam int WORD_BITS = 16;
	localparam logic [7:0] CMD_PREFIX = 8'hc2;
	localparam logic [15:0] CFG_RESET = 16'hc22c;
	localparam logic [7:0] CFG_BYTE_RESET = 8'h2c;
	// configuration byte fields
	localparam int AUTO_LOCK_BIT = 7;
	localparam int MANUAL_SPEED_BIT = 6;
	localparam int FILTER_TYPE_BIT = 4;
	localparam int QUALITY_LSB = 0;
	localparam int QUALITY_BITS = 3;
	// acquisition length in data transitions before lock is declared
	localparam logic [4:0] FAST_LOCK_EDGES = 5'h08;
	localparam logic [4:0] SLOW_LOCK_EDGES = 5'h10;
	localparam logic [4:0] BIT_COUNT_RESET = 5'h00;

	typedef enum logic [1:0] {
		CRL_IDLE = 2'b00,
		CRL_ACQUIRE = 2'b01,
		CRL_LOCKED = 2'b10
	} crl_state_e;
endpackage
`default_nettype wire

// *** hdl/crl_cmd_shift.sv ***
`timescale 1ns/1ps
`default_nettype none
module crl_cmd_shift (
	// system
	input wire logic clock,
	input wire logic rst_n,
	// serial command pins
	input wire logic serClk,
	input wire logic serData,
	input wire logic serSelN,
	// assembled word
	output logic wordValid,
	output logic [15:0] wordData
);
	logic sckPrev_q, sckPrev_d;
	logic [4:0] count_q, count_d;
	logic [15:0] shift_q, shift_d;
	logic valid_q, valid_d;

	// sample on rising serial clock, msb first; deselect restarts the word
	always_comb begin
		sckPrev_d = serClk;
		count_d = count_q;
		shift_d = shift_q;
		valid_d = 1'b0;
		if (serSelN) begin
			count_d = crl_pkg::BIT_COUNT_RESET;
		end else if (serClk && !sckPrev_q) begin
			shift_d = {shift_q[14:0], serData};
			if (count_q == 5'(crl_pkg::WORD_BITS - 1)) begin
				count_d = crl_pkg::BIT_COUNT_RESET;
				valid_d = 1'b1;
			end else begin
				count_d = count_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sckPrev_q <= 1'b0;
			count_q <= crl_pkg::BIT_COUNT_RESET;
			shift_q <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			sckPrev_q <= sckPrev_d;
			count_q <= count_d;
			shift_q <= shift_d;
			valid_q <= valid_d;
		end
	end

	assign wordValid = valid_q;
	assign wordData = shift_q;
endmodule // crl_cmd_shift
`default_nettype wire

// *** hdl/crl_lock_ctrl.sv ***
// Overview of operation
// - reset loads configuration word 0xc22c
// - auto: acquire fast, then slow after lock
// - manual: speed follows speed bit from the first clock after reset, which sets it fast
// - manual fast locks after short preamble
// - manual slow needs longer acquisition, preamble
`timescale 1ns/1ps
`default_nettype none
module crl_lock_ctrl (
	// system
	input wire logic clock,
	input wire logic rst_n,
	// serial command pins from the host
	input wire logic serClk,
	input wire logic serData,
	input wire logic serSelN,
	// recovered data path
	input wire logic carrierValid,
	input wire logic dataEdge,
	// configuration and lock status
	output logic [7:0] configByte,
	output logic autoLock,
	output logic filterType,
	output logic [2:0] qualityThreshold,
	output logic fastMode,
	output logic locked
);
	logic wordValid;
	logic [15:0] wordData;
	logic [7:0] cfg_q, cfg_d;
	crl_pkg::crl_state_e state_q, state_d;
	logic [4:0] edgeCnt_q, edgeCnt_d;
	logic fast_q, fast_d;
	logic lockedOut_q, lockedOut_d;
	logic [4:0] need;

	crl_cmd_shift u_shift (
		.clock(clock),
		.rst_n(rst_n),
		.serClk(serClk),
		.serData(serData),
		.serSelN(serSelN),
		.wordValid(wordValid),
		.wordData(wordData)
	);

	// prefix decode, shared by the byte load and its checks
	function automatic logic is_cfg_word(input logic [15:0] w);
		return w[15:8] == crl_pkg::CMD_PREFIX;
	endfunction

	// only words carrying our prefix touch the byte; others are dropped
	always_comb begin
		cfg_d = cfg_q;
		if (wordValid && is_cfg_word(wordData)) begin
			cfg_d = wordData[7:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= crl_pkg::CFG_BYTE_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// the edge target follows the registered speed, so a speed change
	// mid-acquisition takes effect one cycle later
	assign need = fast_q ? crl_pkg::FAST_LOCK_EDGES :
		crl_pkg::SLOW_LOCK_EDGES;

	// acquisition sequence; losing carrier always restarts it
	always_comb begin
		state_d = state_q;
		edgeCnt_d = edgeCnt_q;
		case (state_q)
			crl_pkg::CRL_IDLE: begin
				edgeCnt_d = crl_pkg::BIT_COUNT_RESET;
				if (carrierValid) begin
					state_d = crl_pkg::CRL_ACQUIRE;
				end
			end
			crl_pkg::CRL_ACQUIRE: begin
				if (!carrierValid) begin
					state_d = crl_pkg::CRL_IDLE;
				end else if (dataEdge) begin
					if (edgeCnt_q >= need - 5'h01) begin
						state_d = crl_pkg::CRL_LOCKED;
					end else begin
						edgeCnt_d = edgeCnt_q + 5'h01;
					end
				end
			end
			crl_pkg::CRL_LOCKED: begin
				if (!carrierValid) begin
					state_d = crl_pkg::CRL_IDLE;
				end
			end
			default: begin
				state_d = crl_pkg::CRL_IDLE;
			end
		endcase
		if (cfg_q[crl_pkg::AUTO_LOCK_BIT]) begin
			fast_d = (state_d != crl_pkg::CRL_LOCKED);
		end else begin
			fast_d = cfg_q[crl_pkg::MANUAL_SPEED_BIT];
		end
		lockedOut_d = (state_d == crl_pkg::CRL_LOCKED);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= crl_pkg::CRL_IDLE;
			edgeCnt_q <= crl_pkg::BIT_COUNT_RESET;
			fast_q <= 1'b1;
			lockedOut_q <= 1'b0;
		end else begin
			state_q <= state_d;
			edgeCnt_q <= edgeCnt_d;
			fast_q <= fast_d;
			lockedOut_q <= lockedOut_d;
		end
	end

	assign configByte = cfg_q;
	assign autoLock = cfg_q[crl_pkg::AUTO_LOCK_BIT];
	assign filterType = cfg_q[crl_pkg::FILTER_TYPE_BIT];
	assign qualityThreshold =
		cfg_q[crl_pkg::QUALITY_LSB +: crl_pkg::QUALITY_BITS];
	assign fastMode = fast_q;
	assign locked = lockedOut_q;

	// helper: high from the second cycle after reset release
	logic seen_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	property p_reset_value;
		@(posedge clock) disable iff (!rst_n)
		!seen_q |-> (configByte == crl_pkg::CFG_BYTE_RESET && fastMode);
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("configuration not at reset value");

	property p_auto_fast;
		@(posedge clock) disable iff (!rst_n)
		(autoLock && state_q == crl_pkg::CRL_ACQUIRE && $stable(autoLock))
			|-> fastMode;
	endproperty
	a_auto_fast: assert property (p_auto_fast)
		else $error("auto acquisition not in fast mode");

	property p_auto_slow;
		@(posedge clock) disable iff (!rst_n)
		($rose(locked) && autoLock && $stable(autoLock)) |-> !fastMode;
	endproperty
	a_auto_slow: assert property (p_auto_slow)
		else $error("auto lock did not switch to slow");

	property p_manual_speed;
		@(posedge clock) disable iff (!rst_n)
		!configByte[crl_pkg::AUTO_LOCK_BIT] |=>
			fastMode == $past(configByte[crl_pkg::MANUAL_SPEED_BIT]);
	endproperty
	a_manual_speed: assert property (p_manual_speed)
		else $error("manual speed bit not followed");

	property p_fast_lock;
		@(posedge clock) disable iff (!rst_n)
		(state_q == crl_pkg::CRL_ACQUIRE && fastMode && carrierValid &&
			dataEdge && edgeCnt_q == 5'h07) |=> locked;
	endproperty
	a_fast_lock: assert property (p_fast_lock)
		else $error("fast mode did not lock on eighth edge");

	property p_slow_wait;
		@(posedge clock) disable iff (!rst_n)
		(state_q == crl_pkg::CRL_ACQUIRE && !fastMode &&
			edgeCnt_q < 5'h0f) |=> !locked;
	endproperty
	a_slow_wait: assert property (p_slow_wait)
		else $error("slow mode locked early");

	property p_slow_lock;
		@(posedge clock) disable iff (!rst_n)
		(state_q == crl_pkg::CRL_ACQUIRE && !fastMode && carrierValid &&
			dataEdge && edgeCnt_q == 5'h0f) |=> locked;
	endproperty
	a_slow_lock: assert property (p_slow_lock)
		else $error("slow mode did not lock on sixteenth edge");

	// lock may only come out of an acquisition step, never from idle
	property p_lock_source;
		@(posedge clock) disable iff (!rst_n)
		$rose(locked) |->
			$past(state_q == crl_pkg::CRL_ACQUIRE && dataEdge);
	endproperty
	a_lock_source: assert property (p_lock_source)
		else $error("lock rose without an acquisition edge");

	property p_prefix_load;
		@(posedge clock) disable iff (!rst_n)
		(wordValid && is_cfg_word(wordData)) |=>
			configByte == $past(wordData[7:0]);
	endproperty
	a_prefix_load: assert property (p_prefix_load)
		else $error("prefixed word not loaded");

	// no prefixed word, no change to the byte
	property p_foreign_hold;
		@(posedge clock) disable iff (!rst_n)
		!(wordValid && is_cfg_word(wordData)) |=> $stable(configByte);
	endproperty
	a_foreign_hold: assert property (p_foreign_hold)
		else $error("byte changed without its prefix");

	c_prefix_write: cover property (@(posedge clock) disable iff (!rst_n)
		wordValid && is_cfg_word(wordData));
	c_auto_lock: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(locked) && autoLock);
	c_manual_slow_lock: cover property (@(posedge clock)
		disable iff (!rst_n) $rose(locked) && !autoLock && !fastMode);
	c_manual_fast_lock: cover property (@(posedge clock)
		disable iff (!rst_n) $rose(locked) && !autoLock && fastMode);
endmodule // crl_lock_ctrl
`default_nettype wire

// *** testbench/crl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module crl_host_model (
	// system
	input wire logic clock,
	// serial command pins
	output logic serClk,
	output logic serData,
	output logic serSelN
);
	// idle: deselected, serial clock still
	initial begin
		serClk = 1'b0;
		serData = 1'b0;
		serSelN = 1'b1;
	end
	// whole word, msb first; each phase lasts one cycle at least
	task automatic send_word(input logic [15:0] w);
		int i;
		@(negedge clock) serSelN = 1'b0;
		for (i = 15; i >= 0; i--) begin
			@(negedge clock) serData = w[i];
			@(negedge clock) serClk = 1'b1;
			@(negedge clock) serClk = 1'b0;
		end
		@(negedge clock) serSelN = 1'b1;
		// released line must not look like valid held data
		serData = ~serData;
	endtask
endmodule // crl_host_model
`default_nettype wire

// *** testbench/crl_lock_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module crl_lock_ctrl_tb;
	logic clock, rst_n, serClk, serData, serSelN, carrierValid, dataEdge;
	logic [7:0] configByte;
	logic [2:0] qualityThreshold;
	logic autoLock, filterType, fastMode, locked;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	// 125 MHz
	always #4 clock = ~clock;
	crl_host_model i_host (.clock(clock), .serClk(serClk),
		.serData(serData), .serSelN(serSelN));
	crl_lock_ctrl i_dut (.clock(clock), .rst_n(rst_n), .serClk(serClk),
		.serData(serData), .serSelN(serSelN), .carrierValid(carrierValid),
		.dataEdge(dataEdge), .configByte(configByte), .autoLock(autoLock),
		.filterType(filterType), .qualityThreshold(qualityThreshold),
		.fastMode(fastMode), .locked(locked));
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// word goes out, byte lands a few edges after the last bit
	task automatic write_cfg(input logic [15:0] w, input logic [7:0] exp);
		i_host.send_word(w);
		repeat (4) @(negedge clock);
		chk("configByte", exp, configByte);
	endtask
	// one transition short of lock, then the locking one, then carrier loss
	task automatic run_lock(input int n, input logic acqF, lockF);
		@(negedge clock) carrierValid = 1'b1;
		repeat (2) @(negedge clock);
		dataEdge = 1'b1;
		repeat (n - 1) @(negedge clock);
		dataEdge = 1'b0;
		@(negedge clock) chk("locked early", 8'h00, {7'h0, locked});
		chk("fastMode acquire", {7'h0, acqF}, {7'h0, fastMode});
		dataEdge = 1'b1;
		@(negedge clock) dataEdge = 1'b0;
		@(negedge clock) chk("locked", 8'h01, {7'h0, locked});
		chk("fastMode locked", {7'h0, lockF}, {7'h0, fastMode});
		carrierValid = 1'b0;
		repeat (2) @(negedge clock);
		chk("locked dropped", 8'h00, {7'h0, locked});
	endtask
	task automatic t_manual_slow();
		run_lock(16, 1'b0, 1'b0);
	endtask
	task automatic t_auto();
		write_cfg(16'hc2d5, 8'hd5);
		chk("autoLock", 8'h01, {7'h0, autoLock});
		chk("filterType", 8'h01, {7'h0, filterType});
		chk("quality", 8'h05, {5'h0, qualityThreshold});
		// foreign prefix must leave the byte alone
		write_cfg(16'h33c0, 8'hd5);
		run_lock(8, 1'b1, 1'b0);
	endtask
	task automatic t_manual_fast();
		write_cfg(16'hc246, 8'h46);
		chk("autoLock", 8'h00, {7'h0, autoLock});
		chk("filterType", 8'h00, {7'h0, filterType});
		chk("quality", 8'h06, {5'h0, qualityThreshold});
		run_lock(8, 1'b1, 1'b1);
	endtask
	// hang guard, far above the few hundred cycles needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			end_of_test();
		end
	end
	// reset, then scenarios in turn
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		carrierValid = 1'b0;
		dataEdge = 1'b0;
		repeat (6) @(negedge clock);
		chk("configByte reset", crl_pkg::CFG_BYTE_RESET, configByte);
		chk("locked reset", 8'h00, {7'h0, locked});
		chk("fastMode reset", 8'h01, {7'h0, fastMode});
		chk("autoLock reset", 8'h00, {7'h0, autoLock});
		rst_n = 1'b1;
		t_manual_slow();
		t_auto();
		t_manual_fast();
		end_of_test();
	end
endmodule // crl_lock_ctrl_tb
`default_nettype wire
